// *** rtl/rcg_pkg.sv ***
// Shared constants, register layout and source codes of the reference clock generator
package rcg_pkg;
	// ************************************************************
	// Bus and register layout
	// ************************************************************
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          DIV_W           = 15;
	localparam int          SEL_W           = 4;
	localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam int          DIV_HI          = 30;
	localparam int          DIV_LO          = 16;
	localparam int          ON_BIT          = 15;
	localparam int          IDLE_STOP_BIT   = 13;
	localparam int          OE_BIT          = 12;
	localparam int          RUN_SLEEP_BIT   = 11;
	localparam int          SWITCH_BIT      = 9;
	localparam int          ACTIVE_BIT      = 8;
	localparam int          SEL_HI          = 3;
	localparam int          SEL_LO          = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	// Cycles the request status lags a change of the enable bit
	localparam int          ACTIVE_SETTLE_CYC = 2;
	localparam int          SETTLE_CNT_W      = 2;

	// ************************************************************
	// Source select codes
	// ************************************************************
	typedef enum logic [3:0] {
		SRC_SYSTEM_CLOCK      = 4'h0,
		SRC_PERIPH_BUS_ONE    = 4'h1,
		SRC_PRIMARY_OSC       = 4'h2,
		SRC_FAST_RC           = 4'h3,
		SRC_LOW_POWER_RC      = 4'h4,
		SRC_SECONDARY_OSC     = 4'h5,
		SRC_RESERVED_6        = 4'h6,
		SRC_SYSTEM_PLL        = 4'h7,
		SRC_REF_CLOCK_IN      = 4'h8,
		SRC_BACKUP_FAST_RC    = 4'h9
	} rcg_src_e;
endpackage

// *** rtl/rcg_divider.sv ***
// Edge-counting divider that turns a sampled source level into the reference clock
`timescale 1ns/1ns
module rcg_divider #(
	parameter int DIV_W = rcg_pkg::DIV_W
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             run,
	input  wire logic             src_level,
	input  wire logic [DIV_W-1:0] div_value,
	input  wire logic             load_req,
	output logic                  clk_out,
	output logic                  load_done
);
	logic             src_q_reg;
	logic [DIV_W-1:0] div_act_reg;
	logic [DIV_W-1:0] cnt_reg;
	logic             src_rise;
	logic             wrap;

	// Source rising edge and end of one half period
	assign src_rise = src_level & ~src_q_reg;
	assign wrap     = src_rise && (cnt_reg == div_act_reg);

	// ************************************************************
	// Source edge detector
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			src_q_reg <= 1'b0;
		end else begin
			src_q_reg <= src_level;
		end
	end

	// Divider value in use; while running from a nonzero value a switch lands only on a half-period boundary to avoid runt pulses
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_act_reg <= '0;
			load_done   <= 1'b0;
		end else begin
			load_done <= 1'b0;
			if (!run) begin
				div_act_reg <= div_value;
				load_done   <= load_req;
			end else if (load_req && (div_act_reg == '0 || wrap)) begin
				div_act_reg <= div_value;
				load_done   <= 1'b1;
			end
		end
	end

	// Half-period counter and output toggle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= {{(DIV_W-1){1'b0}}, 1'b1};
			clk_out <= 1'b0;
		end else if (!run) begin
			cnt_reg <= {{(DIV_W-1){1'b0}}, 1'b1};
			clk_out <= 1'b0;
		end else if (div_act_reg == '0) begin
			clk_out <= src_level;
		end else if (wrap) begin
			cnt_reg <= {{(DIV_W-1){1'b0}}, 1'b1};
			clk_out <= ~clk_out;
		end else if (src_rise) begin
			cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// *** rtl/rcg_top.sv ***
// Reference clock generator: control register, source select, gating and output pin
//
// Notes on behaviour
// - 15-bit divider; zero passes source through
// - Enable bit turns whole generator on
// - Idle-stop bit halts generator in Idle
// - Output enable bit drives clock on pin
// - Run-in-sleep bit keeps output running in Sleep
// - Run-in-sleep ignored for system or bus clock
// - Switch flag set by software, cleared when done
// - Request status bit, read only, hardware owned
// - Source codes zero to five map to sources
// - Codes seven to nine map; others reserved
// - Unimplemented control bits read as zero
`timescale 1ns/1ns
module rcg_top #(
	parameter int DIV_W = rcg_pkg::DIV_W
) (
	input  wire logic                       REF_CLK,
	input  wire logic                       RST_B,
	input  wire logic [rcg_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [rcg_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                       REG_WE,
	input  wire logic                       REG_RE,
	output logic      [rcg_pkg::DATA_W-1:0] REG_RDATA,
	input  wire logic                       SYSTEM_CLOCK,
	input  wire logic                       PERIPHERAL_BUS_CLOCK_ONE,
	input  wire logic                       PRIMARY_OSCILLATOR,
	input  wire logic                       FAST_RC_OSCILLATOR,
	input  wire logic                       LOW_POWER_RC_OSCILLATOR,
	input  wire logic                       SECONDARY_OSCILLATOR,
	input  wire logic                       SYSTEM_PLL_OUTPUT,
	input  wire logic                       REF_CLOCK_IN_PIN,
	input  wire logic                       BACKUP_FAST_RC_OSCILLATOR,
	input  wire logic                       IDLE_MODE,
	input  wire logic                       SLEEP_MODE,
	output logic                            REF_CLOCK_INTERNAL,
	output logic                            REF_CLOCK_OUT_PIN_O,
	output logic                            REF_CLOCK_OUT_PIN_OE_B
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic                                on_reg;
	logic                                idle_stop_reg;
	logic                                out_drive_reg;
	logic                                run_in_sleep_reg;
	logic                                switch_reg;
	logic                                switch_next;
	logic                                active_reg;
	logic [rcg_pkg::SETTLE_CNT_W-1:0]    settle_cnt_reg;
	logic [DIV_W-1:0]                    div_reg;
	logic [rcg_pkg::SEL_W-1:0]           sel_reg;
	logic                                ctrl_hit;
	logic                                ctrl_wr;
	logic                                src_level_reg;
	logic                                src_ok;
	logic                                halt;
	logic                                gen_run;
	logic                                gen_clk;
	logic                                load_done;
	logic [rcg_pkg::DATA_W-1:0]          ctrl_view;

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Reserved codes pick no source, so the generator stays quiet on them
	function automatic logic src_is_valid(input logic [rcg_pkg::SEL_W-1:0] sel);
		case (rcg_pkg::rcg_src_e'(sel))
			rcg_pkg::SRC_SYSTEM_CLOCK,
			rcg_pkg::SRC_PERIPH_BUS_ONE,
			rcg_pkg::SRC_PRIMARY_OSC,
			rcg_pkg::SRC_FAST_RC,
			rcg_pkg::SRC_LOW_POWER_RC,
			rcg_pkg::SRC_SECONDARY_OSC,
			rcg_pkg::SRC_SYSTEM_PLL,
			rcg_pkg::SRC_REF_CLOCK_IN,
			rcg_pkg::SRC_BACKUP_FAST_RC: src_is_valid = 1'b1;
			default: src_is_valid = 1'b0;
		endcase
	endfunction

	// Core clocks stop in Sleep, so the run-in-sleep choice has no meaning for them
	function automatic logic sleep_bit_ignored(input logic [rcg_pkg::SEL_W-1:0] sel);
		sleep_bit_ignored = (sel == rcg_pkg::SRC_SYSTEM_CLOCK) ||
		                    (sel == rcg_pkg::SRC_PERIPH_BUS_ONE);
	endfunction

	// ************************************************************
	// Register port decode
	// ************************************************************
	assign ctrl_hit = (REG_ADDR == rcg_pkg::CTRL_OFFSET);
	assign ctrl_wr  = REG_WE && ctrl_hit;

	// Writable control fields
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			on_reg           <= rcg_pkg::CTRL_RESET[rcg_pkg::ON_BIT];
			idle_stop_reg    <= rcg_pkg::CTRL_RESET[rcg_pkg::IDLE_STOP_BIT];
			out_drive_reg    <= rcg_pkg::CTRL_RESET[rcg_pkg::OE_BIT];
			run_in_sleep_reg <= rcg_pkg::CTRL_RESET[rcg_pkg::RUN_SLEEP_BIT];
			div_reg          <= rcg_pkg::CTRL_RESET[rcg_pkg::DIV_HI:rcg_pkg::DIV_LO];
			sel_reg          <= rcg_pkg::CTRL_RESET[rcg_pkg::SEL_HI:rcg_pkg::SEL_LO];
		end else if (ctrl_wr) begin
			on_reg           <= REG_WDATA[rcg_pkg::ON_BIT];
			idle_stop_reg    <= REG_WDATA[rcg_pkg::IDLE_STOP_BIT];
			out_drive_reg    <= REG_WDATA[rcg_pkg::OE_BIT];
			run_in_sleep_reg <= REG_WDATA[rcg_pkg::RUN_SLEEP_BIT];
			div_reg          <= REG_WDATA[rcg_pkg::DIV_HI:rcg_pkg::DIV_LO];
			sel_reg          <= REG_WDATA[rcg_pkg::SEL_HI:rcg_pkg::SEL_LO];
		end
	end

	// ************************************************************
	// Divider switch flag
	// ************************************************************
	// A software set in the cycle the switch completes wins, so that request is not lost
	always_comb begin
		switch_next = switch_reg;
		if (load_done) begin
			switch_next = 1'b0;
		end
		if (ctrl_wr && REG_WDATA[rcg_pkg::SWITCH_BIT]) begin
			switch_next = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			switch_reg <= rcg_pkg::CTRL_RESET[rcg_pkg::SWITCH_BIT];
		end else begin
			switch_reg <= switch_next;
		end
	end

	// ************************************************************
	// Request status
	// ************************************************************
	// Status trails the enable bit by a short settle time, giving software a window to poll
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			active_reg     <= rcg_pkg::CTRL_RESET[rcg_pkg::ACTIVE_BIT];
			settle_cnt_reg <= '0;
		end else if (on_reg == active_reg) begin
			settle_cnt_reg <= '0;
		end else if (settle_cnt_reg ==
		             rcg_pkg::SETTLE_CNT_W'(rcg_pkg::ACTIVE_SETTLE_CYC - 1)) begin
			active_reg     <= on_reg;
			settle_cnt_reg <= '0;
		end else begin
			settle_cnt_reg <= settle_cnt_reg + 1'b1;
		end
	end

	// ************************************************************
	// Source selection
	// ************************************************************
	// Sources are sampled as levels, so only sources below half the core rate divide cleanly
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			src_level_reg <= 1'b0;
		end else begin
			case (rcg_pkg::rcg_src_e'(sel_reg))
				rcg_pkg::SRC_SYSTEM_CLOCK:   src_level_reg <= SYSTEM_CLOCK;
				rcg_pkg::SRC_PERIPH_BUS_ONE: src_level_reg <= PERIPHERAL_BUS_CLOCK_ONE;
				rcg_pkg::SRC_PRIMARY_OSC:    src_level_reg <= PRIMARY_OSCILLATOR;
				rcg_pkg::SRC_FAST_RC:        src_level_reg <= FAST_RC_OSCILLATOR;
				rcg_pkg::SRC_LOW_POWER_RC:   src_level_reg <= LOW_POWER_RC_OSCILLATOR;
				rcg_pkg::SRC_SECONDARY_OSC:  src_level_reg <= SECONDARY_OSCILLATOR;
				rcg_pkg::SRC_SYSTEM_PLL:     src_level_reg <= SYSTEM_PLL_OUTPUT;
				rcg_pkg::SRC_REF_CLOCK_IN:   src_level_reg <= REF_CLOCK_IN_PIN;
				rcg_pkg::SRC_BACKUP_FAST_RC: src_level_reg <= BACKUP_FAST_RC_OSCILLATOR;
				default:                     src_level_reg <= 1'b0;
			endcase
		end
	end

	// ************************************************************
	// Run gating
	// ************************************************************
	assign src_ok = src_is_valid(sel_reg);
	// Idle stop, and Sleep unless run-in-sleep holds for a source that can run there
	assign halt = (idle_stop_reg && IDLE_MODE) ||
	              (SLEEP_MODE && (!run_in_sleep_reg || sleep_bit_ignored(sel_reg)));
	assign gen_run = on_reg && active_reg && !halt && src_ok;

	rcg_divider #(
		.DIV_W     (DIV_W)
	) u_divider (
		.clk       (REF_CLK),
		.rst_b     (RST_B),
		.run       (gen_run),
		.src_level (src_level_reg),
		.div_value (div_reg),
		.load_req  (switch_reg),
		.clk_out   (gen_clk),
		.load_done (load_done)
	);

	// ************************************************************
	// Clock outputs
	// ************************************************************
	// Pin enable is active low; an undriven pin also has its data held low
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			REF_CLOCK_INTERNAL     <= 1'b0;
			REF_CLOCK_OUT_PIN_O    <= 1'b0;
			REF_CLOCK_OUT_PIN_OE_B <= 1'b1;
		end else begin
			REF_CLOCK_INTERNAL     <= gen_clk && gen_run;
			REF_CLOCK_OUT_PIN_O    <= gen_clk && gen_run && out_drive_reg;
			REF_CLOCK_OUT_PIN_OE_B <= ~out_drive_reg;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Unimplemented bits stay at zero in the assembled word
	always_comb begin
		ctrl_view                                  = '0;
		ctrl_view[rcg_pkg::DIV_HI:rcg_pkg::DIV_LO] = div_reg;
		ctrl_view[rcg_pkg::ON_BIT]                 = on_reg;
		ctrl_view[rcg_pkg::IDLE_STOP_BIT]          = idle_stop_reg;
		ctrl_view[rcg_pkg::OE_BIT]                 = out_drive_reg;
		ctrl_view[rcg_pkg::RUN_SLEEP_BIT]          = run_in_sleep_reg;
		ctrl_view[rcg_pkg::SWITCH_BIT]             = switch_reg;
		ctrl_view[rcg_pkg::ACTIVE_BIT]             = active_reg;
		ctrl_view[rcg_pkg::SEL_HI:rcg_pkg::SEL_LO] = sel_reg;
	end

	// Read data stand only in the cycle after the strobe; other addresses read zero
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			REG_RDATA <= '0;
		end else if (REG_RE && ctrl_hit) begin
			REG_RDATA <= ctrl_view;
		end else begin
			REG_RDATA <= '0;
		end
	end
endmodule

// *** verification/rcg_props.sv ***
// Concurrent checks on the ports of the reference clock generator
`timescale 1ns/1ns
module rcg_props (
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WE,
	input wire logic        REG_RE,
	input wire logic [31:0] REG_RDATA,
	input wire logic        REF_CLOCK_INTERNAL,
	input wire logic        REF_CLOCK_OUT_PIN_O,
	input wire logic        REF_CLOCK_OUT_PIN_OE_B
);
	// ********************
	// Bus and pin checks
	// ********************
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	wire ctrl_wr = REG_WE && REG_ADDR == 8'h00;
	wire ctrl_rd = REG_RE && REG_ADDR == 8'h00;
	// Read data stands only in the cycle after the strobe
	chk_rd_one_cycle: assert property (!$past(REG_RE) |-> REG_RDATA == 32'h0000_0000)
		else $error("read data outside its cycle");
	chk_rd_unmapped: assert property (REG_RE && REG_ADDR != 8'h00 |=> REG_RDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_unimpl_zero: assert property ((REG_RDATA & 32'h8000_44F0) == 32'h0000_0000)
		else $error("unimplemented bit reads one");
	// Pin enable follows the drive bit; a settled released pin carries nothing
	chk_oe_follow: assert property (ctrl_wr |-> ##2
		REF_CLOCK_OUT_PIN_OE_B == !$past(REG_WDATA[12], 2)) else $error("pin enable wrong");
	chk_pin_gated: assert property (
		REF_CLOCK_OUT_PIN_OE_B && $past(REF_CLOCK_OUT_PIN_OE_B) |-> !REF_CLOCK_OUT_PIN_O)
		else $error("released pin toggles");
	// A driven pin carries exactly the internal clock
	chk_pin_int_match: assert property (
		!REF_CLOCK_OUT_PIN_OE_B |-> REF_CLOCK_OUT_PIN_O == REF_CLOCK_INTERNAL)
		else $error("driven pin differs from internal clock");
	chk_flag_reads_set: assert property (
		ctrl_wr && REG_WDATA[9] ##1 ctrl_rd && !REG_WE |=> REG_RDATA[9])
		else $error("switch flag not seen");
	chk_fields_back: assert property (ctrl_wr ##1 ctrl_rd && !REG_WE |=>
		REG_RDATA[30:16] == $past(REG_WDATA[30:16], 2) && REG_RDATA[3:0] == $past(REG_WDATA[3:0], 2))
		else $error("field readback wrong");
	chk_reset_quiet: assert property ($rose(RST_B) |-> REG_RDATA == 32'h0000_0000
		&& !REF_CLOCK_OUT_PIN_O && REF_CLOCK_OUT_PIN_OE_B && !REF_CLOCK_INTERNAL)
		else $error("outputs not quiet after reset");
endmodule

bind rcg_top rcg_props chk_u (.REF_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WE, .REG_RE,
	.REG_RDATA, .REF_CLOCK_INTERNAL, .REF_CLOCK_OUT_PIN_O, .REF_CLOCK_OUT_PIN_OE_B);

// *** verification/rcg_pin_rx.sv ***
// Receiver on the reference clock pin that measures its period
`timescale 1ns/1ns
module rcg_pin_rx (
	input  wire logic        clk,
	input  wire logic        pin_o,
	input  wire logic        pin_oe_b,
	output logic      [15:0] period,
	output logic      [15:0] edges
);
	// ********************
	// Period meter
	// ********************
	logic        lvl;
	logic        lvl_d;
	logic [15:0] cnt;
	// Board pull-down: a released pin reads low
	assign lvl = !pin_oe_b && pin_o;
	initial begin
		lvl_d  = 1'b0;
		cnt    = 16'h0000;
		period = 16'h0000;
		edges  = 16'h0000;
	end
	// Core cycles between two rising edges; wraps only on very long gaps
	always @(posedge clk) begin
		lvl_d <= lvl;
		if (lvl && !lvl_d) begin
			period <= cnt;
			cnt    <= 16'h0001;
			edges  <= edges + 16'h0001;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule

// *** verification/rcg_top_tb.sv ***
// Self-checking testbench of the reference clock generator
`timescale 1ns/1ns
module rcg_top_tb;
	// ********************
	// Stimulus and checks
	// ********************
	localparam logic [31:0] EN  = 32'h0000_8000;
	localparam logic [31:0] IDL = 32'h0000_2000;
	localparam logic [31:0] OE  = 32'h0000_1000;
	localparam logic [31:0] RSL = 32'h0000_0800;
	localparam logic [31:0] SW  = 32'h0000_0200;
	localparam logic [31:0] ACT = 32'h0000_0100;
	logic        clk   = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        we    = 1'b0;
	logic        re    = 1'b0;
	logic        idle  = 1'b0;
	logic        slp   = 1'b0;
	logic [10:0] sc    = 11'h000;
	logic [31:0] rdata;
	logic        pin_o;
	logic        pin_oe_b;
	logic        clk_int;
	logic [15:0] period;
	logic [15:0] edges;
	int          fail_count  = 0;
	int          checks_done = 0;
	always #2 clk = ~clk;
	// Source k runs at a quarter of the core rate over two to the k
	always @(posedge clk) sc <= sc + 11'h001;
	rcg_top dut_u (.REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .SYSTEM_CLOCK(sc[1]),
		.PERIPHERAL_BUS_CLOCK_ONE(sc[2]), .PRIMARY_OSCILLATOR(sc[3]),
		.FAST_RC_OSCILLATOR(sc[4]), .LOW_POWER_RC_OSCILLATOR(sc[5]),
		.SECONDARY_OSCILLATOR(sc[6]), .SYSTEM_PLL_OUTPUT(sc[8]), .REF_CLOCK_IN_PIN(sc[9]),
		.BACKUP_FAST_RC_OSCILLATOR(sc[10]), .IDLE_MODE(idle), .SLEEP_MODE(slp),
		.REF_CLOCK_INTERNAL(clk_int), .REF_CLOCK_OUT_PIN_O(pin_o),
		.REF_CLOCK_OUT_PIN_OE_B(pin_oe_b));
	rcg_pin_rx rx_u (.clk(clk), .pin_o(pin_o), .pin_oe_b(pin_oe_b), .period(period),
		.edges(edges));
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task bad(input string m);
		fail_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	// Bus cycles; callers never issue two writes back to back
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
		q = rdata;
		@(posedge clk);
	endtask
	task cmp_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		checks_done++;
		if (q !== e) bad($sformatf("read %h expected %h", q, e));
	endtask
	// Zero expected means the pin must stay without edges
	task cmp_per(input logic [15:0] e);
		logic [15:0] e0;
		logic [15:0] got;
		int          i;
		repeat (8) @(posedge clk);
		e0 = edges;
		got = 16'h0000;
		if (e == 16'h0000) begin
			repeat (80) @(posedge clk);
			if (edges !== e0) got = 16'hFFFF;
		end else begin
			for (i = 0; i < 9000 && edges - e0 < 16'h0002; i++) @(posedge clk);
			// A stalled pin would leave a stale period behind, so it must not be compared
			if (edges - e0 < 16'h0002) begin
				bad("pin edges timed out");
				finish_test();
			end
			got = period;
		end
		checks_done++;
		if (got !== e) bad($sformatf("period %0d expected %0d", got, e));
	endtask
	// Rising edges of the internal clock over 40 core cycles, sampled mid-cycle
	task cmp_int(input int e);
		int   n;
		int   i;
		logic p;
		n = 0;
		@(negedge clk);
		p = clk_int;
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (clk_int === 1'b1 && p === 1'b0) n++;
			p = clk_int;
		end
		checks_done++;
		if (n != e) bad($sformatf("internal edges %0d expected %0d", n, e));
	endtask
	// Disable, then let the status follow before the next write
	task off;
		wr(8'h00, 32'h0000_0000);
		repeat (4) @(posedge clk);
	endtask
	initial begin
		logic [31:0] q;
		int          i;
		int          c;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		cmp_reg(8'h00, rcg_pkg::CTRL_RESET);
		cmp_reg(8'h04, 32'h0000_0000);
		wr(8'h04, 32'hFFFF_FFFF);
		cmp_reg(8'h00, 32'h0000_0000);
		wr(8'h00, 32'hFFFF_7DFF);
		cmp_reg(8'h00, 32'h7FFF_380F);
		wr(8'h00, 32'hFFFF_FDFF);
		repeat (2) @(posedge clk);
		cmp_reg(8'h00, 32'h7FFF_B90F);
		cmp_per(16'h0000);
		off();
		cmp_reg(8'h00, 32'h0000_0000);
		// Every source code, undivided
		for (c = 0; c < 16; c++) begin
			wr(8'h00, EN | OE | 32'(c));
			cmp_per((c == 6 || c > 9) ? 16'h0000 : 16'h0004 << c);
			off();
		end
		// Divider and a switch while running
		wr(8'h00, 32'h0001_0000 | EN | OE);
		cmp_per(16'h0008);
		wr(8'h00, 32'h0002_0000 | EN | OE | SW);
		cmp_reg(8'h00, 32'h0002_0000 | EN | OE | SW | ACT);
		q = SW;
		for (i = 0; i < 32 && q[9] !== 1'b0; i++) rd(8'h00, q);
		if (q[9] !== 1'b0) begin
			bad("switch flag never cleared");
			finish_test();
		end
		cmp_reg(8'h00, 32'h0002_0000 | EN | OE | ACT);
		cmp_per(16'h0010);
		wr(8'h00, 32'h0003_0000 | EN | OE);
		cmp_per(16'h0010);
		wr(8'h00, OE);
		cmp_per(16'h0000);
		wr(8'h00, EN);
		cmp_per(16'h0000);
		cmp_int(10);
		off();
		// Idle handling
		wr(8'h00, EN | OE | IDL);
		idle <= 1'b1;
		cmp_per(16'h0000);
		wr(8'h00, EN | OE);
		cmp_per(16'h0004);
		idle <= 1'b0;
		off();
		// Sleep handling
		slp <= 1'b1;
		wr(8'h00, EN | OE | RSL | 32'h0000_0002);
		cmp_per(16'h0010);
		wr(8'h00, EN | OE | 32'h0000_0002);
		cmp_per(16'h0000);
		off();
		for (c = 0; c < 2; c++) begin
			wr(8'h00, EN | OE | RSL | 32'(c));
			cmp_per(16'h0000);
			off();
		end
		finish_test();
	end
endmodule
